// ### rtl/aer_read_cmds.sv
// extended sector read and streaming read command handling
`timescale 1ns/1ps
module aer_read_cmds
  import aer_pkg::*;
#(
  parameter logic [15:0] TIME_UNIT_US = 16'h0001,
  parameter logic [23:0] MIN_COMPLETION_TIME_LIMIT_US = 24'h000010
)(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [47:0] media_lba,
  output logic media_go,
  output logic media_ready,
  input wire logic media_valid,
  input wire logic [15:0] media_word,
  input wire logic media_sector_end,
  input wire logic media_unc,
  input wire logic media_id_not_found,
  input wire logic link_crc_error,
  output logic dma_valid,
  output logic [15:0] dma_data,
  input wire logic dma_ready,
  output logic irq
);

  aer_state_t state_q;
  logic [7:0] feat_cur_q, feat_prev_q, cnt_cur_q, cnt_prev_q, devctl_q;
  logic [2:0][7:0] lba_cur_q, lba_prev_q;
  logic [7:0] err_reg_q, err_log_q, status;
  logic err_q, se_q, rc_q, urg_q, stream_q, first_q;
  logic [AER_SID_W-1:0] sid_q;
  logic [15:0] word_q;
  logic word_full_q;
  logic [2:0] irq_stat_q, irq_mask_q, irq_ev;
  logic wr_ok, cmd_wr, go_ext, go_stream, go_bad, go_any;
  logic acc, sec_done, unc_ev, id_not_found_ev, crc_ev, any_err, tmo, hard_stop;
  logic finish_run, fin_pulse, pio_pop, pop, high_order_byte_select, final_sector, expired;
  logic [7:0] err_bits;
  logic [47:0] cur_lba;

  //==============================================================================
  // decode
  //==============================================================================
  // task file is locked while a command runs, as busy promises
  assign wr_ok = reg_wr && state_q == AER_IDLE;
  assign cmd_wr = wr_ok && reg_addr == AER_A_STATCMD;
  assign go_ext = cmd_wr && reg_wdata[7:0] == AER_CMD_READ_EXT; // R1
  assign go_stream = cmd_wr && reg_wdata[7:0] == AER_CMD_READ_STREAM; // R8
  assign go_bad = cmd_wr && !go_ext && !go_stream;
  assign go_any = go_ext || go_stream;
  assign high_order_byte_select = devctl_q[AER_DC_HOB];

  // media events count only when the word is actually accepted
  assign acc = media_valid && media_ready;
  assign sec_done = acc && media_sector_end;
  assign unc_ev = sec_done && media_unc;
  assign id_not_found_ev = sec_done && media_id_not_found;
  assign crc_ev = state_q == AER_RUN && stream_q && link_crc_error; // R7
  assign any_err = unc_ev || id_not_found_ev || crc_ev;
  assign tmo = state_q == AER_RUN && stream_q && expired;
  assign hard_stop = any_err && !rc_q; // R3 R9
  assign err_bits = {crc_ev, unc_ev, 1'b0, id_not_found_ev, 3'b000, tmo};
  // continuous mode only ends on the last sector or the time limit
  assign finish_run = state_q == AER_RUN && (hard_stop || tmo || (sec_done && final_sector)); // R11 R12 R13
  assign fin_pulse = state_q == AER_END && !word_full_q;

  // media side: one word held at a time, so the host paces the media
  assign media_ready = state_q == AER_RUN && !word_full_q;
  assign media_go = state_q == AER_RUN;
  assign media_lba = cur_lba;

  //==============================================================================
  // sub-blocks
  //==============================================================================
  aer_lba_tracker u_track (
    .sys_clk(sys_clk),
    .reset(reset),
    .load(go_any),
    .start_lba({lba_prev_q, lba_cur_q}), // R5
    .count({cnt_prev_q, cnt_cur_q}), // R4
    .step(sec_done),
    .cur_lba(cur_lba),
    .final_sector(final_sector)
  );

  aer_completion_time_limit_timer #(
    .TIME_UNIT_US(TIME_UNIT_US),
    .MIN_COMPLETION_TIME_LIMIT_US(MIN_COMPLETION_TIME_LIMIT_US)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .cfg_we(wr_ok && reg_addr == AER_A_STREAM_CFG),
    .cfg_id(reg_wdata[AER_SID_W-1:0]),
    .cfg_val(reg_wdata[15:8]),
    .start(go_stream),
    .sel_id(go_stream ? feat_cur_q[AER_SID_W-1:0] : sid_q), // R17
    .limit_byte(feat_prev_q), // R15
    .run(state_q != AER_IDLE),
    .expired(expired)
  );

  //==============================================================================
  // command state machine
  //==============================================================================
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state_q <= AER_IDLE;
    else
    begin
      case (state_q)
        AER_IDLE:
          if (go_any)
            state_q <= AER_RUN;
        AER_RUN:
          if (finish_run)
            state_q <= AER_END;
        AER_END:
          if (!word_full_q)
            state_q <= AER_IDLE;
        default:
          state_q <= AER_IDLE;
      endcase
    end
  end

  // mode captured at command write
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      stream_q <= 1'b0;
      rc_q <= 1'b0;
      urg_q <= 1'b0;
      sid_q <= '0;
    end
    else if (go_any)
    begin
      stream_q <= go_stream;
      rc_q <= go_stream && feat_cur_q[AER_F_RC]; // R16
      urg_q <= go_stream && feat_cur_q[AER_F_URG]; // R16
      sid_q <= feat_cur_q[AER_SID_W-1:0];
    end
  end

  //==============================================================================
  // word holder
  //==============================================================================
  // extended read drains via data register, streaming via dma
  assign pio_pop = reg_rd && reg_addr == AER_A_DATA && word_full_q && !stream_q; // R2
  assign dma_valid = word_full_q && stream_q;
  assign dma_data = word_q;
  assign pop = pio_pop || (dma_valid && dma_ready);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      word_q <= 16'h0;
      word_full_q <= 1'b0;
    end
    else if (acc)
    begin
      word_q <= media_word; // R2
      word_full_q <= 1'b1;
    end
    else if (pop)
      word_full_q <= 1'b0;
  end

  //==============================================================================
  // task file
  //==============================================================================
  // writes shift current into previous, giving the 16/48-bit values
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      feat_cur_q <= AER_BYTE_RST;
      feat_prev_q <= AER_BYTE_RST;
      cnt_cur_q <= AER_BYTE_RST;
      cnt_prev_q <= AER_BYTE_RST;
      lba_cur_q <= '0;
      lba_prev_q <= '0;
    end
    else if (state_q == AER_RUN && any_err && !first_q)
    begin
      lba_cur_q <= cur_lba[23:0]; // R6
      lba_prev_q <= cur_lba[47:24]; // R6
    end
    else if (wr_ok)
    begin
      if (reg_addr == AER_A_ERRFEAT)
      begin
        feat_prev_q <= feat_cur_q;
        feat_cur_q <= reg_wdata[7:0];
      end
      if (reg_addr == AER_A_SECCNT)
      begin
        cnt_prev_q <= cnt_cur_q;
        cnt_cur_q <= reg_wdata[7:0];
      end
      for (int i = 0; i < 3; i++)
        if (reg_addr == AER_A_LBA0 + 4'(i))
        begin
          lba_prev_q[i] <= lba_cur_q[i];
          lba_cur_q[i] <= reg_wdata[7:0];
        end
    end
  end

  // device control may change at any time so the host can flip byte select
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      devctl_q <= AER_BYTE_RST;
    else if (reg_wr && reg_addr == AER_A_DEVCTL)
      devctl_q <= reg_wdata[7:0];
  end

  //==============================================================================
  // error, log and stream error
  //==============================================================================
  // continuous mode sends errors to the log, never to the summary bit
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      err_reg_q <= AER_BYTE_RST;
      err_log_q <= AER_BYTE_RST;
      err_q <= 1'b0;
      se_q <= 1'b0;
      first_q <= 1'b0;
    end
    else if (go_any || go_bad)
    begin
      err_reg_q <= go_bad ? (8'h01 << AER_ER_COMMAND_ABORTED) : 8'h00; // R7
      err_q <= go_bad;
      err_log_q <= 8'h00;
      se_q <= 1'b0;
      first_q <= 1'b0;
    end
    else if (state_q == AER_RUN && (any_err || tmo))
    begin
      first_q <= first_q || any_err;
      if (rc_q)
      begin
        err_log_q <= err_log_q | err_bits; // R11 R12
        se_q <= 1'b1; // R10
      end
      else
      begin
        err_reg_q <= err_reg_q | err_bits; // R9
        err_q <= 1'b1;
      end
    end
  end

  // ready is constant: this block never reports a not-ready drive
  assign status = {state_q != AER_IDLE, 1'b1, se_q, 1'b0, word_full_q && !stream_q, 2'b00, err_q}; // R14

  //==============================================================================
  // interrupts
  //==============================================================================
  assign irq_ev[AER_IRQ_DONE] = fin_pulse || go_bad;
  assign irq_ev[AER_IRQ_ERR] = (fin_pulse && err_q) || go_bad;
  assign irq_ev[AER_IRQ_SE] = fin_pulse && se_q;

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_stat_q <= AER_IRQ_RST;
      irq_mask_q <= AER_IRQ_RST;
    end
    else
    begin
      if (reg_wr && reg_addr == AER_A_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~reg_wdata[2:0]) | irq_ev;
      else
        irq_stat_q <= irq_stat_q | irq_ev;
      if (reg_wr && reg_addr == AER_A_IRQ_MASK)
        irq_mask_q <= reg_wdata[2:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  //==============================================================================
  // read port
  //==============================================================================
  // data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 16'h0;
    else if (!reg_rd)
      reg_rdata <= 16'h0;
    else
    begin
      case (reg_addr)
        AER_A_DATA: reg_rdata <= stream_q ? 16'h0 : word_q; // R2
        AER_A_ERRFEAT: reg_rdata <= {8'h00, err_reg_q};
        AER_A_SECCNT: reg_rdata <= {8'h00, high_order_byte_select ? cnt_prev_q : cnt_cur_q};
        4'h3, 4'h4, 4'h5: reg_rdata <= {8'h00, high_order_byte_select ? lba_prev_q[reg_addr - AER_A_LBA0] :
                                        lba_cur_q[reg_addr - AER_A_LBA0]}; // R6
        AER_A_STATCMD: reg_rdata <= {8'h00, status}; // R14
        AER_A_DEVCTL: reg_rdata <= {8'h00, devctl_q};
        AER_A_ERRLOG: reg_rdata <= {8'h00, err_log_q};
        AER_A_IRQ_STAT: reg_rdata <= {13'h0, irq_stat_q};
        AER_A_IRQ_MASK: reg_rdata <= {13'h0, irq_mask_q};
        default: reg_rdata <= 16'h0;
      endcase
    end
  end

  //==============================================================================
  // checks
  //==============================================================================
  AST_CMD_START: assert property (@(posedge sys_clk) disable iff (reset) // R1
    go_ext |=> state_q == AER_RUN && !stream_q) else $error("extended read did not start");
  AST_PIO_DATA: assert property (@(posedge sys_clk) disable iff (reset) // R2
    pio_pop |=> reg_rdata == $past(word_q) && !word_full_q) else $error("data word not delivered");
  AST_UNC_STOP: assert property (@(posedge sys_clk) disable iff (reset) // R3
    (unc_ev && !rc_q) |=> !media_ready && state_q == AER_END) else $error("read went past failing sector");
  AST_ERR_LBA: assert property (@(posedge sys_clk) disable iff (reset) // R6
    (state_q == AER_RUN && any_err && !first_q) |=> {lba_prev_q, lba_cur_q} == $past(cur_lba))
    else $error("failing address not captured");
  AST_EXT_NO_CRC: assert property (@(posedge sys_clk) disable iff (reset) // R7
    !stream_q |-> !err_reg_q[AER_ER_CRC] && !err_reg_q[AER_ER_TIME_LIMIT_EXPIRED]) else $error("bad error bit on extended read");
  AST_RC_NO_ERR: assert property (@(posedge sys_clk) disable iff (reset) // R10
    (state_q != AER_IDLE && rc_q) |-> !err_q) else $error("error summary set in continuous mode");
  AST_RC_GOES_ON: assert property (@(posedge sys_clk) disable iff (reset) // R11
    (rc_q && any_err && !tmo && !(sec_done && final_sector)) |=> state_q == AER_RUN && se_q)
    else $error("continuous read halted on error");
  AST_RC_TMO: assert property (@(posedge sys_clk) disable iff (reset) // R12
    (tmo && rc_q) |=> state_q == AER_END && se_q && err_log_q[AER_ER_TIME_LIMIT_EXPIRED] && !err_q)
    else $error("time limit expiry not handled");
  AST_STATUS: assert property (@(posedge sys_clk) disable iff (reset) // R14
    (reg_rd && reg_addr == AER_A_STATCMD) |=> !reg_rdata[AER_ST_DWE] &&
    reg_rdata[AER_ST_BUSY] == ($past(state_q) != AER_IDLE) && reg_rdata[AER_ST_SE] == $past(se_q))
    else $error("status byte wrong");

  COV_EXT_DONE: cover property (@(posedge sys_clk) disable iff (reset) fin_pulse && !stream_q);
  COV_RC_ERR: cover property (@(posedge sys_clk) disable iff (reset) fin_pulse && se_q);
  COV_TMO: cover property (@(posedge sys_clk) disable iff (reset) tmo);

endmodule

// ### rtl/aer_pkg.sv
// constants, types and register map for the extended read command block
//==============================================================================
// Overview of operation
// R1: command code 24h reads 1 to 65,536 sectors from media to the host.
// R2: extended read delivers sector data via the data register, one 16-bit word each.
// R3: an uncorrectable error ends the extended read at the failing sector.
// R4: sector count is previous byte 15:8 and current byte 7:0; zero means 65,536.
// R5: starting LBA bytes come from sector number and cylinder low/high, current/previous.
// R6: after a hard error the failing LBA is returned with the same byte mapping.
// R7: extended read reports only uncorrectable, not found or aborted; CRC bit stays zero.
// R8: command code 2Ah is the streaming read; count 0000h requests 65536 sectors.
// R9: read-continuous clear gives the normal streaming read, stopping on errors.
// R10: read-continuous delivers the full length without error summary, flags stream error.
// R11: read-continuous errors do not halt; end with stream error and error type logged.
// R12: read-continuous time limit expiry stops with stream error and expiry flag logged.
// R13: the device always tries to deliver the whole amount within the time limit.
// R14: streaming status: busy 7, ready 6, stream error 5, write error 4 zero, request 3, error 0.
// R15: time limit is feature previous times the time unit; zero uses default; minimum enforced.
// R16: feature current bit 6 enables read-continuous, bit 7 asks for urgent completion; bit 7 is latched in urg_q but nothing uses it.
// R17: feature current bits 2:0 pick the stream whose stored settings apply.
// R18: host sets high order byte select before re-reading the upper address bytes.
package aer_pkg;

  // register indices on the plain register port
  localparam logic [3:0] AER_A_DATA = 4'h0;
  localparam logic [3:0] AER_A_ERRFEAT = 4'h1;
  localparam logic [3:0] AER_A_SECCNT = 4'h2;
  localparam logic [3:0] AER_A_LBA0 = 4'h3;
  localparam logic [3:0] AER_A_STATCMD = 4'h7;
  localparam logic [3:0] AER_A_DEVCTL = 4'h8;
  localparam logic [3:0] AER_A_ERRLOG = 4'h9;
  localparam logic [3:0] AER_A_IRQ_STAT = 4'hA;
  localparam logic [3:0] AER_A_IRQ_MASK = 4'hB;
  localparam logic [3:0] AER_A_STREAM_CFG = 4'hC;

  // command codes
  localparam logic [7:0] AER_CMD_READ_EXT = 8'h24;
  localparam logic [7:0] AER_CMD_READ_STREAM = 8'h2A;

  // status bit positions
  localparam int AER_ST_BUSY = 7;
  localparam int AER_ST_READY = 6;
  localparam int AER_ST_SE = 5;
  localparam int AER_ST_DWE = 4;
  localparam int AER_ST_DRQ = 3;
  localparam int AER_ST_ERR = 0;

  // error / error log bit positions
  localparam int AER_ER_CRC = 7;
  localparam int AER_ER_UNC = 6;
  localparam int AER_ER_ID_NOT_FOUND = 4;
  localparam int AER_ER_COMMAND_ABORTED = 2;
  localparam int AER_ER_TIME_LIMIT_EXPIRED = 0;

  // feature current fields, device control field
  localparam int AER_F_URG = 7;
  localparam int AER_F_RC = 6;
  localparam int AER_SID_W = 3;
  localparam int AER_DC_HOB = 7;

  // interrupt status bits
  localparam int AER_IRQ_DONE = 0;
  localparam int AER_IRQ_ERR = 1;
  localparam int AER_IRQ_SE = 2;

  // reset values
  localparam logic [7:0] AER_BYTE_RST = 8'h00;
  localparam logic [2:0] AER_IRQ_RST = 3'h0;

  // timing: one microsecond in clock cycles
  localparam int AER_CLK_PERIOD_NS = 40;
  localparam int AER_US_NS = 1000;
  localparam int AER_CYC_PER_US = (AER_US_NS + AER_CLK_PERIOD_NS - 1) / AER_CLK_PERIOD_NS;

  typedef enum logic [1:0] {AER_IDLE, AER_RUN, AER_END} aer_state_t;

endpackage

// ### rtl/aer_lba_tracker.sv
// sector address and remaining count tracker
`timescale 1ns/1ps
module aer_lba_tracker
  import aer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [47:0] start_lba,
  input wire logic [15:0] count,
  input wire logic step,
  output logic [47:0] cur_lba,
  output logic final_sector
);

  logic [16:0] remain_q;

  //==============================================================================
  // address and count
  //==============================================================================
  // a zero count loads the full 65,536 sectors
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cur_lba <= 48'h0;
      remain_q <= 17'h0;
    end
    else if (load)
    begin
      cur_lba <= start_lba;
      remain_q <= (count == 16'h0) ? 17'h10000 : {1'b0, count}; // R4 R8
    end
    else if (step && remain_q != 17'h0)
    begin
      cur_lba <= cur_lba + 48'h1;
      remain_q <= remain_q - 17'h1;
    end
  end

  // last sector of the request is in flight
  assign final_sector = (remain_q == 17'h1);

endmodule

// ### rtl/aer_completion_time_limit_timer.sv
// completion time limit timer with per-stream default limits
`timescale 1ns/1ps
module aer_completion_time_limit_timer
  import aer_pkg::*;
#(
  parameter logic [15:0] TIME_UNIT_US = 16'h0001,
  parameter logic [23:0] MIN_COMPLETION_TIME_LIMIT_US = 24'h000010
)(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cfg_we,
  input wire logic [AER_SID_W-1:0] cfg_id,
  input wire logic [7:0] cfg_val,
  input wire logic start,
  input wire logic [AER_SID_W-1:0] sel_id,
  input wire logic [7:0] limit_byte,
  input wire logic run,
  output logic expired
);

  logic [7:0] dflt_q [2**AER_SID_W];
  logic [7:0] sel_byte;
  logic [23:0] raw_us;
  logic [23:0] limit_q;
  logic [23:0] us_q;
  logic [4:0] pre_q;
  logic armed_q;

  // explicit limit wins, otherwise the stream's stored default
  assign sel_byte = (limit_byte != 8'h0) ? limit_byte : dflt_q[sel_id]; // R15 R17
  assign raw_us = 24'(sel_byte * TIME_UNIT_US);

  //==============================================================================
  // per-stream default limits
  //==============================================================================
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 2**AER_SID_W; i++)
        dflt_q[i] <= AER_BYTE_RST;
    end
    else if (cfg_we)
      dflt_q[cfg_id] <= cfg_val;
  end

  //==============================================================================
  // microsecond counter
  //==============================================================================
  // zero limit and zero default leave the timer disarmed
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      armed_q <= 1'b0;
      limit_q <= 24'h0;
      us_q <= 24'h0;
      pre_q <= 5'h0;
    end
    else if (start)
    begin
      armed_q <= (sel_byte != 8'h0);
      limit_q <= (raw_us < MIN_COMPLETION_TIME_LIMIT_US) ? MIN_COMPLETION_TIME_LIMIT_US : raw_us; // R15
      us_q <= 24'h0;
      pre_q <= 5'h0;
    end
    else if (run && armed_q && us_q < limit_q)
    begin
      if (pre_q == 5'(AER_CYC_PER_US - 1))
      begin
        pre_q <= 5'h0;
        us_q <= us_q + 24'h1;
      end
      else
        pre_q <= pre_q + 5'h1;
    end
  end

  assign expired = armed_q && (us_q >= limit_q);

endmodule

// ### bench/aer_media_model.sv
// media side model: sectors of four words, one sector may carry an error
`timescale 1ns/1ps
module aer_media_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic media_go,
  input wire logic media_ready,
  input wire logic [1:0] kind,
  input wire logic [15:0] bad,
  output logic media_valid,
  output logic [15:0] media_word,
  output logic media_sector_end,
  output logic media_unc,
  output logic media_id_not_found
);
  logic [15:0] n_q;
  logic hit;
  // word names its running index; idle shows the inverse so stale data never looks valid
  assign media_word = media_valid ? n_q + 16'h1000 : ~(n_q + 16'h1000);
  assign media_sector_end = media_valid && (n_q[1:0] == 2'h3);
  assign hit = media_sector_end && (n_q[15:2] == bad[13:0]);
  assign media_unc = hit && (kind == 2'h1);
  assign media_id_not_found = hit && (kind == 2'h2);
  // valid holds until taken; a one cycle gap after each sector stands for a slow media
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset || !media_go)
    begin
      n_q <= 16'h0000;
      media_valid <= 1'b0;
    end
    else if (media_valid && media_ready)
    begin
      n_q <= n_q + 16'h0001;
      media_valid <= !media_sector_end;
    end
    else
      media_valid <= 1'b1;
  end
endmodule

// ### bench/aer_read_cmds_tb.sv
// self-checking bench for the extended and streaming read commands
`timescale 1ns/1ps
module aer_read_cmds_tb;
  import aer_pkg::*;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
  typedef struct {logic [7:0] cmd, feat; logic [15:0] cnt; logic [1:0] k; logic [15:0] b;
    logic [7:0] st, er; int nw;} aer_row_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic dma_ready = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [1:0] kind = 2'h0;
  logic [15:0] bad = 16'h0000;
  logic [15:0] reg_rdata, media_word, dma_data, rd_q;
  logic [47:0] media_lba, lba_x;
  logic media_go, media_ready, media_valid, media_sector_end, media_unc, media_id_not_found, dma_valid, irq;
  int error_cnt = 0;
  int cmp_count = 0;
  int nw = 0;
  int cyc = 0;
  logic is_ext = 1'b0;
  logic crc_on = 1'b0;
  logic crc_err = 1'b0;
  // rows: command, feature, count, error kind, error sector, status, error byte, words
  aer_row_t rows[7] = '{'{8'h24, 8'h00, 16'h0003, 2'h0, 16'h0, 8'h40, 8'h00, 12},
    '{8'h24, 8'h00, 16'h0004, 2'h1, 16'h1, 8'h41, 8'h40, 8},
    '{8'h24, 8'h00, 16'h0003, 2'h2, 16'h2, 8'h41, 8'h10, 12},
    '{8'h2A, 8'h00, 16'h0101, 2'h0, 16'h0, 8'h40, 8'h00, 1028},
    '{8'h2A, 8'h00, 16'h0003, 2'h1, 16'h0, 8'h41, 8'h40, 4},
    '{8'h2A, 8'h40, 16'h0003, 2'h1, 16'h1, 8'h60, 8'h40, 12},
    '{8'h2A, 8'h41, 16'h0002, 2'h2, 16'h0, 8'h60, 8'h10, 8}};

  always #20 sys_clk = ~sys_clk;

  aer_read_cmds u_aer_read_cmds (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .media_lba(media_lba), .media_go(media_go), .media_ready(media_ready), .media_valid(media_valid),
    .media_word(media_word), .media_sector_end(media_sector_end), .media_unc(media_unc),
    .media_id_not_found(media_id_not_found), .link_crc_error(crc_err), .dma_valid(dma_valid), .dma_data(dma_data),
    .dma_ready(dma_ready), .irq(irq));
  aer_media_model u_aer_media_model (.sys_clk(sys_clk), .reset(reset), .media_go(media_go),
    .media_ready(media_ready), .kind(kind), .bad(bad), .media_valid(media_valid),
    .media_word(media_word), .media_sector_end(media_sector_end), .media_unc(media_unc),
    .media_id_not_found(media_id_not_found));

  // host side stalls every other cycle; each taken word is checked in order
  always @(posedge sys_clk)
  begin
    cyc++;
    dma_ready <= !dma_ready;
    crc_err <= crc_on && nw == 5;
    if (dma_valid && dma_ready)
    begin
      `CHK("dma word", nw[15:0] + 16'h1000, dma_data)
      nw++;
    end
  end
  always @(posedge media_go)
  begin
    #1 `CHK("start lba", lba_x, media_lba)
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  // program the task file, issue, drain until idle; rd_q ends as the final status
  task automatic run(input logic [7:0] cmd, feat, lim, input logic [15:0] cnt, input logic [47:0] lba);
    wr(AER_A_ERRFEAT, {8'h00, lim});
    wr(AER_A_ERRFEAT, {8'h00, feat});
    wr(AER_A_SECCNT, {8'h00, cnt[15:8]});
    wr(AER_A_SECCNT, {8'h00, cnt[7:0]});
    for (int i = 0; i < 3; i++)
    begin
      wr(AER_A_LBA0 + 4'(i), {8'h00, lba[24 + 8 * i +: 8]});
      wr(AER_A_LBA0 + 4'(i), {8'h00, lba[8 * i +: 8]});
    end
    nw = 0;
    lba_x = lba;
    is_ext = (cmd == AER_CMD_READ_EXT);
    wr(AER_A_STATCMD, {8'h00, cmd});
    cyc = 0;
    do
    begin
      rd(AER_A_STATCMD);
      if (is_ext && rd_q[AER_ST_DRQ])
      begin
        rd(AER_A_DATA);
        `CHK("data word", nw[15:0] + 16'h1000, rd_q)
        nw++;
        rd_q = 16'h0080;
      end
    end while ((rd_q[AER_ST_BUSY] || rd_q[AER_ST_DRQ]) && cyc < 20000);
    if (cyc >= 20000) error_cnt++;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #(40 * 60000);
    error_cnt++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rd(AER_A_STATCMD);
    `CHK("reset status", 8'h40, rd_q[7:0])
    `CHK("reset irq", 1'b0, irq)
    wr(AER_A_IRQ_MASK, 16'h0007);
    foreach (rows[i])
    begin
      kind <= rows[i].k;
      bad <= rows[i].b;
      run(rows[i].cmd, rows[i].feat, 8'h00, rows[i].cnt, 48'h000000001000);
      `CHK("status", rows[i].st, rd_q[7:0])
      `CHK("words", rows[i].nw, nw)
      rd(rows[i].feat[AER_F_RC] ? AER_A_ERRLOG : AER_A_ERRFEAT);
      `CHK("error", rows[i].er, rd_q[7:0])
      `CHK("irq done", 1'b1, irq)
      wr(AER_A_IRQ_STAT, 16'h0007);
      $display("row %0d done", i);
    end
    // failing address with both byte selects
    kind <= 2'h1;
    bad <= 16'h0002;
    run(AER_CMD_READ_EXT, 8'h00, 8'h00, 16'h0004, 48'h6655443322FF);
    for (int h = 0; h < 2; h++)
    begin
      wr(AER_A_DEVCTL, h ? 16'h0080 : 16'h0000);
      for (int i = 0; i < 3; i++)
      begin
        rd(AER_A_LBA0 + 4'(i));
        `CHK("fail lba", 48'h665544332301 >> (8 * i + 24 * h) & 48'hFF, {40'h0, rd_q[7:0]})
      end
    end
    wr(AER_A_DEVCTL, 16'h0000);
    $display("failing address test done");
    // unknown command with interrupt masked, then unmasked and cleared
    wr(AER_A_IRQ_STAT, 16'h0007);
    wr(AER_A_IRQ_MASK, 16'h0000);
    wr(AER_A_STATCMD, 16'h00EE);
    rd(AER_A_STATCMD);
    `CHK("abort status", 8'h41, rd_q[7:0])
    rd(AER_A_ERRFEAT);
    `CHK("abort error", 8'h04, rd_q[7:0])
    `CHK("masked irq", 1'b0, irq)
    wr(AER_A_IRQ_MASK, 16'h0007);
    #1 `CHK("unmasked irq", 1'b1, irq)
    wr(AER_A_IRQ_STAT, 16'h0007);
    #1 `CHK("cleared irq", 1'b0, irq)
    rd(4'hF);
    `CHK("unmapped", 16'h0000, rd_q)
    $display("abort test done");
    // count zero continuous read cut by a limit below the minimum of 16 us
    kind <= 2'h0;
    run(AER_CMD_READ_STREAM, 8'h40, 8'h01, 16'h0000, 48'h000000002000);
    `CHK("expiry status", 8'h60, rd_q[7:0])
    `CHK("expiry time", 1'b1, cyc > 390 && cyc < 460)
    `CHK("partial length", 1'b1, nw > 0 && nw < 1000)
    rd(AER_A_ERRLOG);
    `CHK("expiry log", 8'h01, rd_q[7:0])
    // limit byte zero falls back to the default stored for stream 2
    wr(AER_A_STREAM_CFG, 16'h0102);
    run(AER_CMD_READ_STREAM, 8'h42, 8'h00, 16'h0000, 48'h000000002000);
    `CHK("default limit status", 8'h60, rd_q[7:0])
    $display("time limit test done");
    // link crc error mid-transfer must not halt a continuous read
    crc_on = 1'b1;
    run(AER_CMD_READ_STREAM, 8'h40, 8'h00, 16'h0002, 48'h000000003000);
    crc_on = 1'b0;
    `CHK("crc status", 8'h60, rd_q[7:0])
    `CHK("crc words", 8, nw)
    rd(AER_A_ERRLOG);
    `CHK("crc log", 8'h80, rd_q[7:0])
    $display("crc test done");
    report_and_stop();
  end
endmodule
